// ---- pkg/sol_pkg.sv ----
// Shared constants, types and helpers for the strap option latch
package sol_pkg;

   // Register indices; the bus byte address is four times the index
   localparam int SOL_IDX_W = 8;
   localparam int SOL_IDX_LSB = 2;
   localparam logic [7:0] SOL_IDX_CTRL = 8'h00;
   localparam logic [7:0] SOL_IDX_ADV = 8'h04;
   localparam logic [7:0] SOL_IDX_BCAST = 8'h16;
   localparam logic [7:0] SOL_IDX_STAT = 8'h18;

   // Basic control register fields
   localparam int SOL_CTRL_DUPLEX_BIT = 8;
   localparam int SOL_CTRL_ISO_BIT = 10;
   localparam int SOL_CTRL_AN_BIT = 12;
   localparam int SOL_CTRL_SPEED_BIT = 13;
   localparam logic [15:0] SOL_CTRL_RST = 16'h0000;

   // Advertisement register: 10 Mbps abilities and selector set at reset and strap load
   localparam int SOL_ADV_100FD_BIT = 8;
   localparam int SOL_ADV_100HD_BIT = 7;
   localparam logic [15:0] SOL_ADV_BASE = 16'h0061;
   localparam logic [15:0] SOL_ADV_100_MASK = 16'h0180;

   // Broadcast control register
   localparam int SOL_BCAST_OFF_BIT = 9;
   localparam logic [15:0] SOL_BCAST_RST = 16'h0000;
   localparam logic [4:0] SOL_BCAST_ADDR = 5'h00;
   localparam logic [1:0] SOL_ADDR_UPPER = 2'h0;

   // Mode strap codes
   localparam logic [2:0] SOL_MODE_CODE_RMII = 3'h1;
   localparam logic [2:0] SOL_MODE_CODE_B2B = 3'h5;

   // Bus constants
   localparam logic SOL_HRESP_OKAY = 1'h0;
   localparam logic [31:0] SOL_RDATA_NONE = 32'h0000_0000;
   localparam logic [18:0] SOL_STAT_PAD = 19'h0_0000;

   typedef struct packed {
      logic [2:0] addr;
      logic [2:0] mode_code;
      logic isolate;
      logic speed100;
      logic half_duplex;
      logic autoneg_en;
      logic bcast_off;
   } sol_straps_t;

   localparam sol_straps_t SOL_STRAP_DFLT = '{addr: 3'h1, mode_code: 3'h1, isolate: 1'h0,
      speed100: 1'h1, half_duplex: 1'h1, autoneg_en: 1'h1, bcast_off: 1'h0};

   typedef enum logic [1:0] {
      SOL_MODE_RMII = 2'b00,
      SOL_MODE_B2B = 2'b01,
      SOL_MODE_RSVD = 2'b10
   } sol_mode_t;

   typedef enum logic [1:0] {
      SOL_SMP_RESET = 2'b00,
      SOL_SMP_LOAD = 2'b01,
      SOL_SMP_RUN = 2'b10
   } sol_smp_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] index;
   } sol_dphase_t;

   function automatic sol_mode_t sol_decode_mode(input logic [2:0] code);
      sol_mode_t m;
      case (code)
         SOL_MODE_CODE_RMII: m = SOL_MODE_RMII;
         SOL_MODE_CODE_B2B: m = SOL_MODE_B2B;
         default: m = SOL_MODE_RSVD;
      endcase
      return m;
   endfunction : sol_decode_mode

   function automatic logic [7:0] sol_reg_index(input logic [31:0] haddr);
      return haddr[SOL_IDX_LSB +: SOL_IDX_W];
   endfunction : sol_reg_index

endpackage : sol_pkg

// ---- rtl/sol_sampler.sv ----
// Strap sampler: catches the strap pins once at reset release
`timescale 1ns/10ps
module sol_sampler import sol_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Strap pins
   input wire sol_straps_t strap_pins,
   // Latched configuration
   output sol_straps_t latched,
   output sol_mode_t mode,
   output logic load
);

   sol_smp_state_t state;

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= SOL_SMP_RESET;
      end else begin
         case (state)
            SOL_SMP_RESET: state <= SOL_SMP_LOAD;
            SOL_SMP_LOAD: state <= SOL_SMP_RUN;
            SOL_SMP_RUN: state <= SOL_SMP_RUN;
            default: state <= SOL_SMP_RESET;
         endcase
      end
   end

   // Pins are only looked at in the first cycle after release, so a MAC that
   // drives them later cannot disturb the configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         latched <= SOL_STRAP_DFLT;
      end else if (state == SOL_SMP_RESET) begin
         latched <= strap_pins;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= SOL_MODE_RMII;
      end else if (state == SOL_SMP_RESET) begin
         mode <= sol_decode_mode(strap_pins.mode_code);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         load <= 1'h0;
      end else begin
         load <= (state == SOL_SMP_RESET);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_capture_once: assert property (
      $fell(rst) |=> (latched == $past(strap_pins)) ##1 (load == 1'h0)
   ) else $error("Straps not captured at reset release");

   chk_hold_latch: assert property (
      (state == SOL_SMP_RUN) |=> $stable(latched) && $stable(mode)
   ) else $error("Latched straps changed without reset");

   chk_mode_rmii: assert property (
      load && (latched.mode_code == SOL_MODE_CODE_RMII) |-> (mode == SOL_MODE_RMII)
   ) else $error("Normal mode code decoded wrongly");

   chk_mode_b2b: assert property (
      load && (latched.mode_code == SOL_MODE_CODE_B2B) |-> (mode == SOL_MODE_B2B)
   ) else $error("Back-to-back mode code decoded wrongly");

   cov_mode_reserved: cover property (load && (mode == SOL_MODE_RSVD));

endmodule : sol_sampler

// ---- rtl/sol_top.sv ----
// Strap option latch with AHB-Lite register slave
// Behaviour
// - Sample every strap once at reset release; use as initial configuration.
// - Management address low three bits from address straps; default one.
// - Address zero is broadcast unless strap or register 16h bit 9 set.
// - Upper two management address bits are zero.
// - Mode code 001 is RMII, 101 back-to-back; others reserved.
// - Isolate strap loads control bit 10; high enables isolate.
// - Speed strap loads control bit 13; high selects 100 Mbps.
// - Speed strap also sets advertised 100 Mbps abilities in register 4h.
// - Duplex strap loads control bit 8; high selects half duplex.
// - Autoneg strap loads control bit 12; high enables auto-negotiation.
`timescale 1ns/10ps
module sol_top import sol_pkg::*; (
   // Clock and reset
   input wire logic MCLK,
   input wire logic SYS_RST,
   // Strap pins
   input wire logic [2:0] MGMT_ADDR_STRAP,
   input wire logic [2:0] MODE_STRAP,
   input wire logic ISOLATE_STRAP,
   input wire logic SPEED_STRAP,
   input wire logic DUPLEX_STRAP,
   input wire logic AUTONEG_ENABLE_STRAP,
   input wire logic BCAST_DISABLE_STRAP,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Management address match
   input wire logic [4:0] MGMT_QUERY_ADDR,
   output logic ADDR_HIT,
   // Configuration outputs
   output logic [4:0] MGMT_ADDR,
   output logic BCAST_ENABLE,
   output logic ISOLATE,
   output logic SPEED_100,
   output logic HALF_DUPLEX,
   output logic AUTONEG_EN,
   output logic MODE_B2B,
   output logic MODE_RESERVED,
   output logic CONFIG_VALID
);

   sol_straps_t strap_pins;
   sol_straps_t strap_q;
   sol_mode_t mode_q;
   logic load;
   sol_dphase_t dphase;
   logic addr_take;
   logic wr_ctrl;
   logic wr_adv;
   logic wr_bcast;
   logic [15:0] wr_lo;
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic [15:0] adv;
   logic [15:0] next_adv;
   logic [15:0] bcast_ctl;
   logic [15:0] next_bcast_ctl;
   logic [15:0] strap_ctrl;
   logic bcast_off_now;

   assign strap_pins = '{addr: MGMT_ADDR_STRAP, mode_code: MODE_STRAP,
      isolate: ISOLATE_STRAP, speed100: SPEED_STRAP, half_duplex: DUPLEX_STRAP,
      autoneg_en: AUTONEG_ENABLE_STRAP, bcast_off: BCAST_DISABLE_STRAP};

   sol_sampler u_sampler (
      .clk(MCLK),
      .rst(SYS_RST),
      .strap_pins(strap_pins),
      .latched(strap_q),
      .mode(mode_q),
      .load(load)
   );

   // One write decode shared by all three writable registers
   function automatic logic wr_hit(input sol_dphase_t dp, input logic [7:0] idx);
      return dp.valid && dp.write && (dp.index == idx);
   endfunction : wr_hit

   // Bus slave: zero wait states, so each data phase lasts one cycle
   assign addr_take = HSEL && HREADY && HTRANS[1];
   assign wr_lo = HWDATA[15:0];
   assign wr_ctrl = wr_hit(dphase, SOL_IDX_CTRL);
   assign wr_adv = wr_hit(dphase, SOL_IDX_ADV);
   assign wr_bcast = wr_hit(dphase, SOL_IDX_BCAST);

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         dphase <= '0;
      end else if (HREADY) begin
         dphase <= '{valid: addr_take, write: HWRITE, index: sol_reg_index(HADDR)};
      end
   end

   // Control word built from the latched straps
   always_comb begin
      strap_ctrl = SOL_CTRL_RST;
      strap_ctrl[SOL_CTRL_ISO_BIT] = strap_q.isolate;
      strap_ctrl[SOL_CTRL_SPEED_BIT] = strap_q.speed100;
      strap_ctrl[SOL_CTRL_DUPLEX_BIT] = strap_q.half_duplex;
      strap_ctrl[SOL_CTRL_AN_BIT] = strap_q.autoneg_en;
   end

   // The strap load wins over a bus write in the same cycle; software may
   // rewrite every loaded bit afterwards
   always_comb begin
      next_ctrl = ctrl;
      if (load) begin
         next_ctrl = strap_ctrl;
      end else if (wr_ctrl) begin
         next_ctrl = wr_lo;
      end
   end

   always_comb begin
      next_adv = adv;
      if (load) begin
         next_adv = SOL_ADV_BASE | (strap_q.speed100 ? SOL_ADV_100_MASK : SOL_CTRL_RST);
      end else if (wr_adv) begin
         next_adv = wr_lo;
      end
   end

   always_comb begin
      next_bcast_ctl = bcast_ctl;
      if (wr_bcast) begin
         next_bcast_ctl = wr_lo;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         ctrl <= SOL_CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         adv <= SOL_ADV_BASE | SOL_ADV_100_MASK;
      end else begin
         adv <= next_adv;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         bcast_ctl <= SOL_BCAST_RST;
      end else begin
         bcast_ctl <= next_bcast_ctl;
      end
   end

   // Read data uses next values so a read right behind a write sees it
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         HRDATA <= SOL_RDATA_NONE;
      end else if (addr_take && !HWRITE) begin
         case (sol_reg_index(HADDR))
            SOL_IDX_CTRL: HRDATA <= {16'h0000, next_ctrl};
            SOL_IDX_ADV: HRDATA <= {16'h0000, next_adv};
            SOL_IDX_BCAST: HRDATA <= {16'h0000, next_bcast_ctl};
            SOL_IDX_STAT: HRDATA <= {SOL_STAT_PAD, mode_q, strap_q};
            default: HRDATA <= SOL_RDATA_NONE;
         endcase
      end
   end

   // Never stalls and never errors; unmapped writes are dropped
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         HREADYOUT <= 1'h1;
         HRESP <= SOL_HRESP_OKAY;
      end else begin
         HREADYOUT <= 1'h1;
         HRESP <= SOL_HRESP_OKAY;
      end
   end

   // Management address and broadcast handling
   assign bcast_off_now = strap_q.bcast_off || bcast_ctl[SOL_BCAST_OFF_BIT];

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         MGMT_ADDR <= {SOL_ADDR_UPPER, SOL_STRAP_DFLT.addr};
      end else if (load) begin
         MGMT_ADDR <= {SOL_ADDR_UPPER, strap_q.addr};
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         BCAST_ENABLE <= 1'h1;
         ADDR_HIT <= 1'h0;
      end else begin
         BCAST_ENABLE <= !bcast_off_now;
         ADDR_HIT <= (MGMT_QUERY_ADDR == MGMT_ADDR) ||
            ((MGMT_QUERY_ADDR == SOL_BCAST_ADDR) && !bcast_off_now);
      end
   end

   // Mode outputs; a reserved code is only flagged, the block cannot fix it
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         MODE_B2B <= 1'h0;
         MODE_RESERVED <= 1'h0;
         CONFIG_VALID <= 1'h0;
      end else if (load) begin
         MODE_B2B <= (mode_q == SOL_MODE_B2B);
         MODE_RESERVED <= (mode_q == SOL_MODE_RSVD);
         CONFIG_VALID <= 1'h1;
      end
   end

   assign ISOLATE = ctrl[SOL_CTRL_ISO_BIT];
   assign SPEED_100 = ctrl[SOL_CTRL_SPEED_BIT];
   assign HALF_DUPLEX = ctrl[SOL_CTRL_DUPLEX_BIT];
   assign AUTONEG_EN = ctrl[SOL_CTRL_AN_BIT];

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   chk_addr_low: assert property (
      load |=> (MGMT_ADDR[2:0] == strap_q.addr)
   ) else $error("Low address bits not loaded from straps");

   chk_addr_high: assert property (
      CONFIG_VALID |-> (MGMT_ADDR[4:3] == SOL_ADDR_UPPER)
   ) else $error("Upper address bits not zero");

   chk_bcast_hit: assert property (
      (MGMT_QUERY_ADDR == SOL_BCAST_ADDR) && !strap_q.bcast_off &&
      !bcast_ctl[SOL_BCAST_OFF_BIT] |=> ADDR_HIT && BCAST_ENABLE
   ) else $error("Address zero not answered as broadcast");

   chk_bcast_unique: assert property (
      (MGMT_QUERY_ADDR == SOL_BCAST_ADDR) && (MGMT_ADDR != SOL_BCAST_ADDR) &&
      (strap_q.bcast_off || bcast_ctl[SOL_BCAST_OFF_BIT]) |=> !ADDR_HIT
   ) else $error("Address zero answered while broadcast is off");

   chk_iso_load: assert property (
      load |=> (ISOLATE == strap_q.isolate)
   ) else $error("Isolate bit not loaded from strap");

   chk_speed_load: assert property (
      load |=> (SPEED_100 == strap_q.speed100)
   ) else $error("Speed bit not loaded from strap");

   chk_adv_speed: assert property (
      load |=> (adv[SOL_ADV_100FD_BIT] == strap_q.speed100) &&
      (adv[SOL_ADV_100HD_BIT] == strap_q.speed100)
   ) else $error("Advertised 100 Mbps abilities do not follow strap");

   chk_duplex_load: assert property (
      load |=> (HALF_DUPLEX == strap_q.half_duplex)
   ) else $error("Duplex bit not loaded from strap");

   chk_an_load: assert property (
      load |=> (AUTONEG_EN == strap_q.autoneg_en)
   ) else $error("Autoneg bit not loaded from strap");

   chk_ctrl_write: assert property (
      wr_ctrl && !load |=> (ctrl == $past(wr_lo))
   ) else $error("Control register write lost");

   chk_cfg_valid: assert property (
      load |=> CONFIG_VALID
   ) else $error("Configuration not flagged valid after strap load");

   chk_bcast_write: assert property (
      wr_bcast |=> (bcast_ctl == $past(wr_lo))
   ) else $error("Broadcast control write lost");

   chk_adv_write: assert property (
      wr_adv && !load |=> (adv == $past(wr_lo))
   ) else $error("Advertisement register write lost");

   // Loaded bits keep their value unless software or a new load moves them
   chk_ctrl_hold: assert property (
      !load && !wr_ctrl |=> $stable(ctrl)
   ) else $error("Control register changed without cause");

   chk_adv_hold: assert property (
      !load && !wr_adv |=> $stable(adv)
   ) else $error("Advertisement register changed without cause");

   chk_mgmt_hold: assert property (
      !load |=> $stable(MGMT_ADDR)
   ) else $error("Management address changed without reset");

   cov_b2b_boot: cover property (load ##1 MODE_B2B);
   cov_bcast_unique: cover property (CONFIG_VALID && !BCAST_ENABLE && (MGMT_QUERY_ADDR == SOL_BCAST_ADDR));
   cov_ctrl_write: cover property (CONFIG_VALID && wr_ctrl);
   cov_bcast_hit: cover property (ADDR_HIT && BCAST_ENABLE && (MGMT_QUERY_ADDR == SOL_BCAST_ADDR));

endmodule : sol_top

// ---- verification/sol_strap_board.sv ----
// Board model: strap pulls and MAC-side drivers on the shared strap pins
`timescale 1ns/10ps
module sol_strap_board import sol_pkg::*; (
   // Controls
   input wire logic strong_pulls,
   input wire logic mac_drive_rst,
   input wire logic mac_on,
   // Pin levels
   input wire sol_straps_t pulls,
   input wire sol_straps_t mac_val,
   output sol_straps_t pins
);
   always_comb begin
      if (mac_on) begin
         // After reset the shared pins carry MAC traffic and LED levels
         pins = mac_val;
      end else if (mac_drive_rst && !strong_pulls) begin
         // Weak pulls lose to a MAC driving during reset
         pins = mac_val;
      end else begin
         pins = pulls;
      end
   end
endmodule : sol_strap_board

// ---- verification/strap_option_latch_tb_top.sv ----
// Self-checking testbench for the strap option latch
`timescale 1ns/10ps
module strap_option_latch_tb_top import sol_pkg::*; ;
   localparam logic [31:0] A_CTRL = {22'h0, SOL_IDX_CTRL, 2'h0};
   localparam logic [31:0] A_ADV = {22'h0, SOL_IDX_ADV, 2'h0};
   localparam logic [31:0] A_BCAST = {22'h0, SOL_IDX_BCAST, 2'h0};
   localparam logic [31:0] A_STAT = {22'h0, SOL_IDX_STAT, 2'h0};
   localparam sol_straps_t DFLT = '{3'h1, 3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   localparam sol_straps_t ALT = '{3'h5, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic mclk, sys_rst, hsel, hwrite, hreadyout, hresp, addr_hit, bcast_enable;
   logic isolate, speed_100, half_duplex, autoneg_en, mode_b2b, mode_reserved, config_valid;
   logic strong_pulls, mac_drive_rst, mac_on;
   logic [1:0] htrans;
   logic [4:0] query, mgmt_addr;
   logic [31:0] haddr, hwdata, hrdata;
   sol_straps_t pulls, mac_val, pins;
   int bad_count, checks_done, cycles;

   sol_strap_board board_u (.strong_pulls(strong_pulls), .mac_drive_rst(mac_drive_rst),
      .mac_on(mac_on), .pulls(pulls), .mac_val(mac_val), .pins(pins));

   sol_top dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .MGMT_ADDR_STRAP(pins.addr),
      .MODE_STRAP(pins.mode_code), .ISOLATE_STRAP(pins.isolate), .SPEED_STRAP(pins.speed100),
      .DUPLEX_STRAP(pins.half_duplex), .AUTONEG_ENABLE_STRAP(pins.autoneg_en),
      .BCAST_DISABLE_STRAP(pins.bcast_off), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .MGMT_QUERY_ADDR(query), .ADDR_HIT(addr_hit),
      .MGMT_ADDR(mgmt_addr), .BCAST_ENABLE(bcast_enable), .ISOLATE(isolate),
      .SPEED_100(speed_100), .HALF_DUPLEX(half_duplex), .AUTONEG_EN(autoneg_en),
      .MODE_B2B(mode_b2b), .MODE_RESERVED(mode_reserved), .CONFIG_VALID(config_valid));

   always #10 mclk = ~mclk;

   // Cut a hang short; the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Single word transfer; the master never assumes a wait count
   task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
         output logic [31:0] rdata);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= addr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rdata = hrdata;
      chk({31'h0, hresp}, 32'h0000_0000);
   endtask : bus_xfer

   task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
      logic [31:0] r;
      bus_xfer(1'b0, addr, 32'h0000_0000, r);
      chk(r, exp);
   endtask : rd_chk

   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      logic [31:0] r;
      bus_xfer(1'b1, addr, data, r);
   endtask : wr

   task automatic do_reset(input sol_straps_t s);
      pulls <= s;
      mac_on <= 1'b0;
      sys_rst <= 1'b1;
      repeat (20) @(posedge mclk);
      chk({30'h0, hreadyout, config_valid}, 32'h0000_0002);
      chk({27'h0, mgmt_addr}, 32'h0000_0001);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : do_reset

   task automatic query_chk(input logic [4:0] a, input logic exp);
      @(posedge mclk);
      query <= a;
      repeat (2) @(posedge mclk);
      chk({31'h0, addr_hit}, {31'h0, exp});
   endtask : query_chk

   task automatic cfg_chk(input sol_straps_t s);
      logic [15:0] c;
      c = 16'h0000;
      c[SOL_CTRL_ISO_BIT] = s.isolate;
      c[SOL_CTRL_SPEED_BIT] = s.speed100;
      c[SOL_CTRL_DUPLEX_BIT] = s.half_duplex;
      c[SOL_CTRL_AN_BIT] = s.autoneg_en;
      chk({31'h0, config_valid}, 32'h0000_0001);
      chk({27'h0, mgmt_addr}, {29'h0, s.addr});
      chk({31'h0, bcast_enable}, {31'h0, !s.bcast_off});
      chk({31'h0, isolate}, {31'h0, s.isolate});
      chk({31'h0, speed_100}, {31'h0, s.speed100});
      chk({31'h0, half_duplex}, {31'h0, s.half_duplex});
      chk({31'h0, autoneg_en}, {31'h0, s.autoneg_en});
      rd_chk(A_CTRL, {16'h0, c});
      rd_chk(A_ADV, {16'h0, SOL_ADV_BASE | (s.speed100 ? SOL_ADV_100_MASK : 16'h0)});
   endtask : cfg_chk

   task automatic test_defaults();
      do_reset(DFLT);
      cfg_chk(DFLT);
      rd_chk(A_STAT, 32'h0000_012E);
      query_chk(5'h00, 1'b1);
      query_chk(5'h01, 1'b1);
      query_chk(5'h09, 1'b0);
   endtask : test_defaults

   // MAC drives the inverse during reset but strong pulls hold the intent
   task automatic test_driven_pins();
      strong_pulls <= 1'b1;
      mac_drive_rst <= 1'b1;
      mac_val <= ~ALT;
      do_reset(ALT);
      cfg_chk(ALT);
      chk({30'h0, mode_b2b, mode_reserved}, 32'h0000_0002);
      rd_chk(A_STAT, 32'h0000_0DB1);
      query_chk(5'h00, 1'b0);
      query_chk(5'h05, 1'b1);
   endtask : test_driven_pins

   // Pins change after release; nothing latched may follow them
   task automatic test_hold_and_write();
      mac_val <= DFLT;
      mac_on <= 1'b1;
      repeat (10) @(posedge mclk);
      cfg_chk(ALT);
      rd_chk(A_STAT, 32'h0000_0DB1);
      wr(A_CTRL, 32'h0000_2100);
      rd_chk(A_CTRL, 32'h0000_2100);
      chk({28'h0, isolate, speed_100, half_duplex, autoneg_en}, 32'h0000_0006);
      mac_drive_rst <= 1'b0;
   endtask : test_hold_and_write

   task automatic test_bcast_reg();
      do_reset(DFLT);
      wr(A_BCAST, 32'h0000_0200);
      repeat (2) @(posedge mclk);
      chk({31'h0, bcast_enable}, 32'h0000_0000);
      rd_chk(A_BCAST, 32'h0000_0200);
      query_chk(5'h00, 1'b0);
      rd_chk(32'h0000_0044, 32'h0000_0000);
   endtask : test_bcast_reg

   task automatic test_modes();
      sol_straps_t s;
      s = DFLT;
      for (int i = 0; i < 8; i++) begin
         s.mode_code = i[2:0];
         do_reset(s);
         chk({31'h0, mode_b2b}, {31'h0, i == 5});
         chk({31'h0, mode_reserved}, {31'h0, i != 1 && i != 5});
      end
   endtask : test_modes

   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      query = 5'h00;
      pulls = DFLT;
      mac_val = DFLT;
      strong_pulls = 1'b0;
      mac_drive_rst = 1'b0;
      mac_on = 1'b0;
      bad_count = 0;
      checks_done = 0;
      cycles = 0;
      test_defaults();
      test_driven_pins();
      test_hold_and_write();
      test_bcast_reg();
      test_modes();
      tally_and_finish();
   end
endmodule : strap_option_latch_tb_top
